/* File: include/rgs_defs.svh */
`ifndef RGS_DEFS_SVH
`define RGS_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define RGS_IDX_CTRL 10'h02C
`define RGS_IDX_PEAK 10'h02D
`define RGS_IDX_SPACE 10'h03F
// address bits the decoder looks at; anything above must be zero
`define RGS_ADDR_SPAN 12

// reset values
`define RGS_CTRL_RST 8'h00
`define RGS_AUTO_RST 4'h0
`define RGS_SPACE_RST 1'b0
`define RGS_PEAK_RST 4'h0

// control register fields
`define RGS_SRC_BIT 7
`define RGS_MAN_HI 6
`define RGS_MAN_LO 3
`define RGS_MSEL_HI 2
`define RGS_MSEL_LO 0
`define RGS_SRC_MANUAL 1'b1

// readout, peak and space select register fields
`define RGS_AUTO_HI 7
`define RGS_AUTO_LO 4
`define RGS_AM_HI 7
`define RGS_AM_LO 4
`define RGS_PM_HI 3
`define RGS_PM_LO 0
`define RGS_SPACE_BIT 0

// supply measure selector codes
`define RGS_MSEL_LAST 3'h4

// regulated voltages in millivolts, and the lowest code used in 3.3 V mode
`define RGS_MV_BASE_5V 13'h0E10
`define RGS_MV_STEP 13'h0064
`define RGS_MV_DROP_3V3 13'h06A4
`define RGS_MV_FIXED_DA 13'h0D48
`define RGS_CODE_MIN_3V3 4'h5

`endif

/* File: include/rgs_pkg.sv */
`default_nettype none
package rgs_pkg;
	typedef logic [3:0] rgs_code_t;
	typedef logic [12:0] rgs_mv_t;
	typedef logic [7:0] rgs_byte_t;
	// supplies the measure command can sample, in selector code order
	typedef enum logic [2:0] {
		RGS_SUP_MAIN,
		RGS_SUP_ANALOG,
		RGS_SUP_DIGITAL,
		RGS_SUP_RF,
		RGS_SUP_AM
	} rgs_supply_e;
endpackage
`default_nettype wire

/* File: rtl/rgs_peak_hold.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rgs_defs.svh"
module rgs_peak_hold #(
	parameter int CODE_W = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// comparator bank, one bit per threshold, lowest first
	input wire logic [(1 << CODE_W) - 2:0] level_thermo,
	// restart of the peak
	input wire logic restart,
	// held peak code
	output logic [CODE_W - 1:0] peak_q
);
	localparam int NTH = (1 << CODE_W) - 1;

	if (CODE_W < 1 || CODE_W > 6) begin : g_bad_width
		$error("rgs_peak_hold: CODE_W must be 1 to 6");
	end

	logic [NTH - 1:0] thermo_m_q;
	logic [NTH - 1:0] thermo_q;
	logic [CODE_W - 1:0] level_code;
	logic [CODE_W - 1:0] peak_d;

	// two flops: comparator outputs come from the analog side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thermo_m_q <= '0;
			thermo_q <= '0;
		end else begin
			thermo_m_q <= level_thermo;
			thermo_q <= thermo_m_q;
		end
	end

	// highest tripped threshold wins, so bubbles cannot make the code fall
	always_comb begin
		level_code = '0;
		for (int i = 0; i < NTH; i++) begin
			if (thermo_q[i]) begin
				level_code = CODE_W'(i + 1);
			end
		end
	end

	assign peak_d = restart ? '0 : ((level_code > peak_q) ? level_code : peak_q);

	// peak follows the largest code seen since the last restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peak_q <= '0;
		end else begin
			peak_q <= peak_d;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_code_zero_quiet: assert property (thermo_q == '0 |-> level_code == '0)
		else $error("level code not zero with no threshold tripped");
	chk_code_top_full: assert property (thermo_q == '1 |-> level_code == CODE_W'(NTH))
		else $error("level code not full scale with all thresholds tripped");
endmodule // rgs_peak_hold
`default_nettype wire

/* File: rtl/rgs_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rgs_defs.svh"
module rgs_regs #(
	parameter int ADDR_W = 12,
	parameter int CODE_W = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [ADDR_W - 1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// adjust regulators command result
	input wire logic adjust_done,
	input wire rgs_pkg::rgs_code_t adjust_code,
	// supply mode strap pin, high in 5 V mode
	input wire logic supply_5v_pin,
	// measure power supply command
	input wire logic measure_cmd,
	output logic measure_go,
	output rgs_pkg::rgs_supply_e measure_source,
	output logic measure_refused,
	// reception and clear peak strength command
	input wire logic rx_start,
	input wire logic clear_peak,
	input wire logic [(1 << CODE_W) - 2:0] am_level_thermo,
	input wire logic [(1 << CODE_W) - 2:0] pm_level_thermo,
	// regulator settings
	output rgs_pkg::rgs_code_t rf_reg_code,
	output rgs_pkg::rgs_mv_t rf_target_mv,
	output logic da_fixed,
	output rgs_pkg::rgs_mv_t da_target_mv
);
	import rgs_pkg::*;

	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
		$error("rgs_regs: ADDR_W must be 12 to 32");
	end
	if (CODE_W != 4) begin : g_bad_code
		$error("rgs_regs: peak register holds two 4-bit codes");
	end

	rgs_byte_t ctrl_q;
	rgs_code_t auto_q;
	logic space_b_q;
	logic [31:0] prdata_q;
	logic mode_m_q;
	logic mode_5v_q;
	rgs_code_t rf_code_q;
	rgs_mv_t rf_mv_q;
	rgs_mv_t da_mv_q;
	logic da_fixed_q;
	logic go_q;
	logic refused_q;
	rgs_supply_e source_q;
	rgs_code_t am_peak;
	rgs_code_t pm_peak;

	// bus phase decode
	wire apb_setup = psel & ~penable;
	wire apb_access = psel & penable;
	wire [9:0] word_idx = paddr[11:2];
	wire aligned = (paddr[1:0] == 2'b00) & ((paddr >> `RGS_ADDR_SPAN) == '0);

	// register hits; the shared index is split by the space bit
	wire hit_idx_ctrl = aligned & (word_idx == `RGS_IDX_CTRL);
	wire hit_ctrl_a = hit_idx_ctrl & ~space_b_q;
	wire hit_auto_b = hit_idx_ctrl & space_b_q;
	wire hit_peak = aligned & (word_idx == `RGS_IDX_PEAK) & ~space_b_q;
	wire hit_space = aligned & (word_idx == `RGS_IDX_SPACE);
	wire mapped = hit_ctrl_a | hit_auto_b | hit_peak | hit_space;

	// write strobes; only the low byte lane carries register data
	wire wr_low = apb_access & pwrite & pstrb[0];
	wire wr_ctrl = wr_low & hit_ctrl_a;
	wire wr_space = wr_low & hit_space;

	// read data of each register, unused bits zero
	wire [31:0] rd_ctrl = {24'h00_0000, ctrl_q};
	wire [31:0] rd_auto = {24'h00_0000, auto_q, 4'h0};
	wire [31:0] rd_peak = {24'h00_0000, am_peak, pm_peak};
	wire [31:0] rd_space = {31'h0000_0000, space_b_q};
	wire [31:0] rd_mux = hit_ctrl_a ? rd_ctrl :
		hit_auto_b ? rd_auto :
		hit_peak ? rd_peak :
		hit_space ? rd_space : 32'h0000_0000;

	// zero wait state: data is captured in setup, the answer comes in access
	assign pready = 1'b1;
	assign pslverr = apb_access & ~mapped;
	assign prdata = prdata_q;

	// read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (apb_setup & ~pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	// control register; readout and peak have no write path at all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `RGS_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[7:0];
		end
	end

	// register space select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			space_b_q <= `RGS_SPACE_RST;
		end else if (wr_space) begin
			space_b_q <= pwdata[`RGS_SPACE_BIT];
		end
	end

	// last adjust regulators result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_q <= `RGS_AUTO_RST;
		end else if (adjust_done) begin
			auto_q <= adjust_code;
		end
	end

	// supply mode strap comes from a pin: two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_m_q <= 1'b0;
			mode_5v_q <= 1'b0;
		end else begin
			mode_m_q <= supply_5v_pin;
			mode_5v_q <= mode_m_q;
		end
	end

	// regulator code source and target voltages
	wire src_manual = (ctrl_q[`RGS_SRC_BIT] == `RGS_SRC_MANUAL);
	wire [3:0] man_code = ctrl_q[`RGS_MAN_HI:`RGS_MAN_LO];
	wire [3:0] sel_code = src_manual ? man_code : auto_q;
	wire [3:0] low_code = (sel_code < `RGS_CODE_MIN_3V3) ? `RGS_CODE_MIN_3V3 : sel_code;
	wire [3:0] mv_code = mode_5v_q ? sel_code : low_code;
	wire [12:0] mv_steps = `RGS_MV_STEP * {9'h000, mv_code};
	wire [12:0] mv_5v = `RGS_MV_BASE_5V + mv_steps;
	wire [12:0] rf_mv_d = mode_5v_q ? mv_5v : (mv_5v - `RGS_MV_DROP_3V3);
	wire [12:0] da_mv_d = mode_5v_q ? `RGS_MV_FIXED_DA : rf_mv_d;

	// regulator outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rf_code_q <= `RGS_AUTO_RST;
			rf_mv_q <= `RGS_MV_BASE_5V;
			da_mv_q <= `RGS_MV_FIXED_DA;
			da_fixed_q <= 1'b0;
		end else begin
			rf_code_q <= sel_code;
			rf_mv_q <= rf_mv_d;
			da_mv_q <= da_mv_d;
			da_fixed_q <= mode_5v_q;
		end
	end

	assign rf_reg_code = rf_code_q;
	assign rf_target_mv = rf_mv_q;
	assign da_target_mv = da_mv_q;
	assign da_fixed = da_fixed_q;

	// measure selector; reserved codes refuse the command
	wire [2:0] msel = ctrl_q[`RGS_MSEL_HI:`RGS_MSEL_LO];
	wire msel_ok = (msel <= `RGS_MSEL_LAST);

	// measure command launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_q <= 1'b0;
			refused_q <= 1'b0;
			source_q <= RGS_SUP_MAIN;
		end else begin
			go_q <= measure_cmd & msel_ok;
			refused_q <= measure_cmd & ~msel_ok;
			if (measure_cmd & msel_ok) begin
				source_q <= rgs_supply_e'(msel);
			end
		end
	end

	assign measure_go = go_q;
	assign measure_refused = refused_q;
	assign measure_source = source_q;

	// peak strength channels: a new reception or clear restarts both
	wire peak_restart = rx_start | clear_peak;
	wire [1:0][(1 << CODE_W) - 2:0] ch_thermo = {am_level_thermo, pm_level_thermo};
	rgs_code_t ch_peak [2];

	for (genvar g = 0; g < 2; g++) begin : g_chan
		rgs_peak_hold #(
			.CODE_W(CODE_W)
		) u_peak (
			.pclk(pclk),
			.presetn(presetn),
			.level_thermo(ch_thermo[g]),
			.restart(peak_restart),
			.peak_q(ch_peak[g])
		);
	end

	assign am_peak = ch_peak[1];
	assign pm_peak = ch_peak[0];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_src_auto_path: assert property (!src_manual |=> rf_reg_code == $past(auto_q))
		else $error("rf code does not follow adjust result in auto mode");
	chk_manual_voltage: assert property (src_manual && mode_5v_q
		|=> rf_target_mv == `RGS_MV_BASE_5V + `RGS_MV_STEP * {9'h000, $past(man_code)})
		else $error("manual 5 V target voltage wrong");
	chk_da_fixed_5v: assert property (mode_5v_q |=> da_target_mv == `RGS_MV_FIXED_DA && da_fixed)
		else $error("digital/analog not fixed in 5 V mode");
	chk_da_follow_3v3: assert property (!mode_5v_q |=> da_target_mv == rf_target_mv && !da_fixed)
		else $error("digital/analog not following rf in 3.3 V mode");
	chk_measure_launch: assert property (measure_cmd && msel_ok
		|=> measure_go && !measure_refused && measure_source == rgs_supply_e'($past(msel)))
		else $error("measure command not launched with its supply");
	chk_measure_reserved: assert property (measure_cmd && !msel_ok |=> !measure_go && measure_refused)
		else $error("reserved measure selector not refused");
	chk_readout_data: assert property (apb_setup && !pwrite && hit_auto_b
		|=> prdata[7:4] == $past(auto_q) && prdata[3:0] == 4'h0)
		else $error("readout register data wrong");
	chk_peak_hold: assert property (!peak_restart |=> am_peak >= $past(am_peak) && pm_peak >= $past(pm_peak))
		else $error("peak strength fell without restart");
	chk_peak_clear: assert property (peak_restart |=> am_peak == 4'h0 && pm_peak == 4'h0)
		else $error("peak strength not cleared");
	chk_space_split: assert property (apb_access && pwrite && hit_idx_ctrl && space_b_q |=> $stable(ctrl_q))
		else $error("space B write reached control register");
	chk_ro_ignored: assert property (apb_access && pwrite && (hit_auto_b || hit_peak) && !adjust_done
		|=> $stable(auto_q))
		else $error("write disturbed read-only register");

	// bus answers: error flag, read data and its hold between reads
	chk_peak_space_b: assert property (apb_access && aligned && word_idx == `RGS_IDX_PEAK && space_b_q
		|-> pslverr)
		else $error("peak index in space B not flagged as unmapped");
	chk_error_idle: assert property (!apb_access
		|-> !pslverr)
		else $error("error flag raised outside an access phase");
	chk_unmapped_read_zero: assert property (apb_setup && !pwrite && !mapped
		|=> prdata == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");
	chk_rdata_hold: assert property (!(apb_setup && !pwrite)
		|=> $stable(prdata))
		else $error("read data changed without a read setup");
	chk_ctrl_read_data: assert property (apb_setup && !pwrite && hit_ctrl_a
		|=> prdata == {24'h00_0000, $past(ctrl_q)})
		else $error("control register read data wrong");
	chk_peak_read_data: assert property (apb_setup && !pwrite && hit_peak
		|=> prdata == {24'h00_0000, $past(am_peak), $past(pm_peak)})
		else $error("peak register read data wrong");

	// register writes land only through their own strobe
	chk_ctrl_write_lands: assert property (wr_ctrl
		|=> ctrl_q == $past(pwdata[7:0]))
		else $error("control write did not land");
	chk_ctrl_hold: assert property (!wr_ctrl
		|=> $stable(ctrl_q))
		else $error("control register changed without a write");
	chk_space_write: assert property (wr_space
		|=> space_b_q == $past(pwdata[`RGS_SPACE_BIT]))
		else $error("space select write did not land");
	chk_strobe_gate: assert property (apb_access && pwrite && !pstrb[0]
		|=> $stable(ctrl_q) && $stable(space_b_q))
		else $error("write without low byte strobe changed a register");

	// adjust result capture and hold
	chk_adjust_capture: assert property (adjust_done
		|=> auto_q == $past(adjust_code))
		else $error("adjust result not captured");
	chk_adjust_hold: assert property (!adjust_done
		|=> $stable(auto_q))
		else $error("readout code changed without an adjust result");

	// lowest target the rf regulator may ever be given in 3.3 V mode
	localparam rgs_mv_t MV_FLOOR_3V3 = `RGS_MV_BASE_5V + `RGS_MV_STEP * {9'h000, `RGS_CODE_MIN_3V3} - `RGS_MV_DROP_3V3;

	// regulator code and voltage ranges
	chk_src_manual_path: assert property (src_manual
		|=> rf_reg_code == $past(man_code))
		else $error("rf code does not follow manual code");
	chk_rf_floor_5v: assert property (mode_5v_q
		|=> rf_target_mv >= `RGS_MV_BASE_5V)
		else $error("5 V rf target below the lowest code");
	chk_rf_floor_3v3: assert property (!mode_5v_q
		|=> rf_target_mv >= MV_FLOOR_3V3)
		else $error("3.3 V rf target below the lowest listed code");
	chk_da_flag_mode: assert property (da_fixed
		|-> da_target_mv == `RGS_MV_FIXED_DA)
		else $error("fixed flag set without the fixed voltage");

	// measure command pulses come only from a command
	chk_measure_idle: assert property (!measure_cmd
		|=> !measure_go && !measure_refused)
		else $error("measure answer without a command");
	chk_source_held: assert property (!(measure_cmd && msel_ok)
		|=> $stable(measure_source))
		else $error("measure source changed without an accepted command");
	chk_go_cause: assert property (measure_go || measure_refused
		|-> $past(measure_cmd))
		else $error("measure answer not preceded by a command");

	cov_manual_mode: cover property (wr_ctrl && pwdata[`RGS_SRC_BIT]);
	cov_measure_refused: cover property (measure_refused);
	cov_peak_cleared: cover property (clear_peak && am_peak != 4'h0);
	cov_readout_read: cover property (apb_access && !pwrite && hit_auto_b);
	cov_space_b_error: cover property (apb_access && space_b_q && !mapped);
endmodule // rgs_regs
`default_nettype wire

/* File: dv/rgs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rgs_defs.svh"
module regulator_and_signal_strength_regs_tb_top;
	import rgs_pkg::*;
	// bench-driven inputs
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, lf = 32'he47f_a1ce, ctl;
	logic [3:0] pstrb = 4'hf, adjust_code = '0, a, p, k;
	logic adjust_done = 0, supply_5v_pin = 0, measure_cmd = 0, rx_start = 0, clear_peak = 0;
	logic [14:0] am_level_thermo = '0, pm_level_thermo = '0;
	// design outputs
	logic [31:0] prdata;
	logic pready, pslverr, measure_go, measure_refused, da_fixed;
	rgs_supply_e measure_source;
	rgs_code_t rf_reg_code;
	rgs_mv_t rf_target_mv, da_target_mv;
	// expected results and counters
	logic [32:0] rd_q[$];
	logic [4:0] ms_q[$];
	logic [2:0] last_src = 3'h0;
	int miscompares = 0, checked = 0;

	always #5 pclk = ~pclk;

	rgs_regs #(.ADDR_W(12), .CODE_W(4)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .adjust_done, .adjust_code, .supply_5v_pin,
		.measure_cmd, .measure_go, .measure_source, .measure_refused, .rx_start, .clear_peak,
		.am_level_thermo, .pm_level_thermo, .rf_reg_code, .rf_target_mv, .da_fixed, .da_target_mv);

	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task complete_run;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer, held until pready is sampled high
	task apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		paddr <= ad;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			$display("Error at %0t: no pready within the wait bound", $time);
			complete_run;
		end
		psel <= 0;
		penable <= 0;
	endtask

	task rd(input logic [11:0] ad, input logic [32:0] e);
		rd_q.push_back(e);
		apb(ad, 1'b0, 32'h0);
	endtask

	// regulator outputs expected for a code and a supply mode
	task exp_reg(input logic [3:0] c, input logic m);
		int mv;
		mv = 3600 + 100 * c - (m ? 0 : 1700);
		if (!m && c < 5)
			mv = 2400;
		chk(33'(rf_reg_code), 33'(c));
		chk(33'(rf_target_mv), 33'(mv));
		chk(33'(da_target_mv), m ? 33'd3400 : 33'(mv));
		chk(33'(da_fixed), 33'(m));
	endtask

	// monitor: read data and measure answers against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (rd_q.size() == 0)
				chk(0, 1);
			else
				chk({pslverr, prdata}, rd_q.pop_front());
		end
		if (measure_go === 1'b1 || measure_refused === 1'b1) begin
			if (ms_q.size() == 0)
				chk(0, 1);
			else
				chk(33'({measure_go, measure_refused, measure_source}), 33'(ms_q.pop_front()));
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		$display("Error at %0t: run limit reached", $time);
		complete_run;
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rd(12'h0b0, 33'h0);
		rd(12'h0b4, 33'h0);
		rd(12'h100, {1'b1, 32'h0});
		rd(12'h0b2, {1'b1, 32'h0});
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			lf = nxt(lf);
			supply_5v_pin <= lf[8];
			ctl = {24'h0, 1'b1, lf[3:0], 3'h0};
			apb(12'h0b0, 1'b1, ctl);
			cyc(5);
			exp_reg(lf[3:0], lf[8]);
		end
		pstrb <= 4'he;
		apb(12'h0b0, 1'b1, 32'h0);
		pstrb <= 4'hf;
		rd(12'h0b0, {1'b0, ctl});
		$display("manual code done");
		lf = nxt(lf);
		k = lf[11:8];
		apb(12'h0b0, 1'b1, 32'h0);
		adjust_code <= k;
		adjust_done <= 1;
		cyc(1);
		adjust_done <= 0;
		cyc(3);
		exp_reg(k, supply_5v_pin);
		apb(12'h0fc, 1'b1, 32'h1);
		rd(12'h0b0, {25'h0, k, 4'h0});
		apb(12'h0b0, 1'b1, 32'hff);
		rd(12'h0b0, {25'h0, k, 4'h0});
		rd(12'h0b4, {1'b1, 32'h0});
		rd(12'h0fc, 33'h1);
		apb(12'h0fc, 1'b1, 32'h0);
		rd(12'h0b0, 33'h0);
		$display("adjust and readout done");
		for (int s = 0; s < 8; s++) begin
			apb(12'h0b0, 1'b1, 32'(s));
			if (s < 5)
				last_src = 3'(s);
			ms_q.push_back(s < 5 ? {2'b10, last_src} : {2'b01, last_src});
			measure_cmd <= 1;
			cyc(1);
			measure_cmd <= 0;
			cyc(2);
		end
		$display("measure select done");
		for (int j = 0; j < 4; j++) begin
			lf = nxt(lf);
			a = lf[3:0];
			p = lf[7:4];
			am_level_thermo <= 15'((16'h1 << a) - 1);
			pm_level_thermo <= 15'((16'h1 << p) - 1);
			cyc(5);
			rd(12'h0b4, {25'h0, a, p});
			am_level_thermo <= '0;
			pm_level_thermo <= '0;
			cyc(5);
			apb(12'h0b4, 1'b1, 32'h0);
			rd(12'h0b4, {25'h0, a, p});
			if (j[0])
				clear_peak <= 1;
			else
				rx_start <= 1;
			cyc(1);
			clear_peak <= 0;
			rx_start <= 0;
			cyc(2);
			rd(12'h0b4, 33'h0);
		end
		$display("peak hold done");
		cyc(3);
		chk(33'(rd_q.size() + ms_q.size()), 33'h0);
		complete_run;
	end
endmodule // regulator_and_signal_strength_regs_tb_top
`default_nettype wire
